// ### hw/hdp_dev.sv
// Device end: network RAM and code memory behind the host port.
// Assumes pins reach it through hdp_if; core side is plain ports.
`timescale 1ns/100ps
`include "hdp_regs.svh"
module hdp_dev #(
	parameter int DW = `HDP_DATA_W,
	parameter int AW = `HDP_ADDR_W
) (
	input  wire logic          mclk,
	input  wire logic          reset,
	hdp_if.dev                 pins,
	input  wire logic [1:0]    ready_high_code,
	input  wire logic          event_req,
	input  wire logic          event_clr,
	output logic               event_pending_q,
	output logic               wr_seen_q,
	output logic [AW-1:0]      wr_addr_q
);
	logic [DW-1:0]        ram_q [0:(1<<AW)-1];
	logic [2:0]           ce_s;
	logic [2:0]           we_s;
	logic [2:0]           oe_s;
	logic [2:0]           hc_s;
	logic [1:0]           mode_s;
	logic [AW-1:0]        addr_s1_q;
	logic [AW-1:0]        addr_s2_q;
	logic [DW-1:0]        din_s1_q;
	logic [DW-1:0]        din_s2_q;
	hdp_pkg::hdp_dev_st_t st_q;
	logic [2:0]           hi_cnt_q;
	logic [2:0]           wait_q;
	logic                 is_wr_q;
	logic                 done_o_q;
	logic                 done_oe_q;
	logic                 dout_oe_q;
	logic                 irq_oe_q;
	logic [DW-1:0]        dout_q;
	logic                 ce_n;
	logic                 we_n;
	logic                 oe_n;
	logic                 hclk_rise;
	logic                 wr_act;
	logic                 rd_act;
	logic                 any_act;
	logic                 use_hc;

	function automatic logic [2:0] hi_len(input logic [1:0] c);
		case (c)
			2'b00: hi_len = 3'(`HDP_HI_CYC0);
			2'b01: hi_len = 3'(`HDP_HI_CYC1);
			2'b10: hi_len = 3'(`HDP_HI_CYC2);
			default: hi_len = 3'(`HDP_HI_CYC3);
		endcase
	endfunction : hi_len

	// Extra wait cycles so done never beats the access minimum
	function automatic logic [2:0] min_wait(input logic wr);
		if (wr) begin
			min_wait = 3'(`HDP_WR_MIN_CYC - `HDP_SYNC_LAT);
		end else begin
			min_wait = 3'(`HDP_RD_MIN_CYC - `HDP_SYNC_LAT);
		end
	endfunction : min_wait

	// Two-flop synchronisers; bit 0 is read only by bit 1
	always_ff @(posedge mclk) begin
		ce_s <= {ce_s[1], ce_s[0], pins.chip_select_n};
		we_s <= {we_s[1], we_s[0], pins.write_strobe_n};
		oe_s <= {oe_s[1], oe_s[0], pins.output_strobe_n};
		hc_s <= {hc_s[1], hc_s[0], pins.host_bus_clock};
		mode_s <= {mode_s[0], pins.use_host_clock};
		addr_s1_q <= pins.addr;
		addr_s2_q <= addr_s1_q;
		din_s1_q <= pins.data;
		din_s2_q <= din_s1_q;
	end
	assign ce_n = ce_s[1];
	assign we_n = we_s[1];
	assign oe_n = oe_s[1];
	assign hclk_rise = hc_s[1] & ~hc_s[2];
	assign wr_act = ~ce_n & ~we_n;
	assign rd_act = ~ce_n & ~oe_n;
	assign any_act = wr_act | rd_act;
	assign use_hc = mode_s[1];

	// Single word store; upper half of the map is code memory
	always_ff @(posedge mclk) begin
		if (st_q == hdp_pkg::HDP_IDLE && wr_act) begin
			ram_q[addr_s2_q] <= din_s2_q;
		end
		if (st_q == hdp_pkg::HDP_IDLE && rd_act) begin
			dout_q <= ram_q[addr_s2_q];
		end
	end

	// Access sequencer: done within 1..4 cycles for writes, 1.5..8 for reads
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q      <= hdp_pkg::HDP_IDLE;
			done_o_q  <= 1'b1;
			done_oe_q <= 1'b0;
			hi_cnt_q  <= 3'h0;
			wait_q    <= 3'h0;
			is_wr_q   <= 1'b0;
		end else begin
			case (st_q)
				hdp_pkg::HDP_IDLE: begin
					if (any_act) begin
						is_wr_q <= wr_act;
						wait_q  <= min_wait(wr_act);
						st_q    <= hdp_pkg::HDP_WAIT;
					end
				end
				hdp_pkg::HDP_WAIT: begin
					if (!any_act) begin
						st_q <= hdp_pkg::HDP_IDLE;
					end else if (wait_q != 3'h0) begin
						wait_q <= wait_q - 3'h1;
					end else if (!use_hc || hclk_rise) begin
						done_o_q  <= 1'b0;
						done_oe_q <= 1'b1;
						st_q      <= hdp_pkg::HDP_DONE;
					end
				end
				hdp_pkg::HDP_DONE: begin
					// Async: hold until strobes end; sync: one host clock
					if ((!use_hc && !any_act) || (use_hc && hclk_rise)) begin
						done_o_q  <= 1'b1;
						hi_cnt_q  <= hi_len(ready_high_code);
						st_q      <= hdp_pkg::HDP_HIGH;
					end
				end
				hdp_pkg::HDP_HIGH: begin
					// Drive high briefly, then release to pull-up
					if (hi_cnt_q <= 3'h1) begin
						done_oe_q <= 1'b0;
						if (!any_act) begin
							st_q <= hdp_pkg::HDP_IDLE;
						end
					end else begin
						hi_cnt_q <= hi_cnt_q - 3'h1;
					end
				end
				default: begin
					st_q      <= hdp_pkg::HDP_IDLE;
					done_oe_q <= 1'b0;
					done_o_q  <= 1'b1;
				end
			endcase
		end
	end

	// Data bus driven one cycle after the synchronised read strobes are both low with the sequencer out of idle
	always_ff @(posedge mclk) begin
		if (reset) begin
			dout_oe_q <= 1'b0;
		end else begin
			dout_oe_q <= rd_act && st_q != hdp_pkg::HDP_IDLE;
		end
	end

	// Write report to the core
	always_ff @(posedge mclk) begin
		if (reset) begin
			wr_seen_q <= 1'b0;
			wr_addr_q <= '0;
		end else begin
			wr_seen_q <= st_q == hdp_pkg::HDP_IDLE && wr_act;
			if (st_q == hdp_pkg::HDP_IDLE && wr_act) begin
				wr_addr_q <= addr_s2_q;
			end
		end
	end

	// Event flag; a new event wins over the clear
	always_ff @(posedge mclk) begin
		if (reset) begin
			event_pending_q <= 1'b0;
			irq_oe_q        <= 1'b0;
		end else begin
			event_pending_q <= event_req | (event_pending_q & ~event_clr);
			irq_oe_q        <= event_req | (event_pending_q & ~event_clr);
		end
	end

	assign pins.dev_data_o  = dout_q;
	assign pins.dev_data_oe = dout_oe_q;
	assign pins.done_o      = done_o_q;
	assign pins.done_oe     = done_oe_q;
	assign pins.irq_oe      = irq_oe_q;
endmodule : hdp_dev

// ### hw/hdp_regs.svh
// Constants for the host dual-port RAM port: widths, timing counts.
// Assumes a 125 MHz mclk (8 ns period).
`ifndef HDP_REGS_SVH
`define HDP_REGS_SVH
`define HDP_DATA_W       16
`define HDP_ADDR_W       12
`define HDP_CLK_PS       8000
`define HDP_TC_PS        25000
// Write answer window 1..4 controller cycles, read 1.5..8
`define HDP_WR_MIN_PS    25000
`define HDP_RD_MIN_PS    37500
`define HDP_WR_MIN_CYC   ((`HDP_WR_MIN_PS + `HDP_CLK_PS - 1) / `HDP_CLK_PS)
`define HDP_RD_MIN_CYC   ((`HDP_RD_MIN_PS + `HDP_CLK_PS - 1) / `HDP_CLK_PS)
// Edges from first strobe sample to the first wait cycle
`define HDP_SYNC_LAT     3
// Least gap between accesses and after a control-enable write
`define HDP_GAP_PS       5000
`define HDP_GAP_CYC      ((`HDP_GAP_PS + `HDP_CLK_PS - 1) / `HDP_CLK_PS)
`define HDP_RR_PS        37500
`define HDP_RR_CYC       ((`HDP_RR_PS + `HDP_CLK_PS - 1) / `HDP_CLK_PS)
`define HDP_INIT_PS      200000
`define HDP_INIT_CYC     ((`HDP_INIT_PS + `HDP_CLK_PS - 1) / `HDP_CLK_PS)
// Drive-high codes of the access-done release, in mclk cycles
`define HDP_HI_CYC0      1
`define HDP_HI_CYC1      2
`define HDP_HI_CYC2      3
`define HDP_HI_CYC3      4
// Address window split: code memory above this word address
`define HDP_CODE_BASE    12'h800
`endif

// ### hw/hdp_pkg.sv
// Types shared by both ends of the host dual-port RAM port.
// Assumes hdp_regs.svh constants.
package hdp_pkg;
	typedef enum logic [1:0] {
		HDP_IDLE = 2'b00,
		HDP_WAIT = 2'b01,
		HDP_DONE = 2'b11,
		HDP_HIGH = 2'b10
	} hdp_dev_st_t;
	typedef enum logic [2:0] {
		HDP_H_IDLE  = 3'b000,
		HDP_H_SETUP = 3'b001,
		HDP_H_STROB = 3'b011,
		HDP_H_END   = 3'b010,
		HDP_H_GAP   = 3'b110
	} hdp_host_st_t;
endpackage : hdp_pkg

// ### hw/hdp_if.sv
// Pin bundle between host bus logic and the dual-port RAM port.
// Resolves the shared data bus and open-drain lines from the enables.
`timescale 1ns/100ps
interface hdp_if;
	logic [11:0] addr;
	logic        chip_select_n;
	logic        write_strobe_n;
	logic        output_strobe_n;
	logic [15:0] host_data_o;
	logic        host_data_oe;
	logic [15:0] dev_data_o;
	logic        dev_data_oe;
	logic [15:0] data;
	logic        done_o;
	logic        done_oe;
	logic        access_done_n;
	logic        irq_oe;
	logic        event_irq_n;
	logic        host_bus_clock;
	logic        use_host_clock;
	// Weak pull-ups where nobody drives
	assign data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 16'hffff);
	assign access_done_n = done_oe ? done_o : 1'b1;
	assign event_irq_n   = irq_oe ? 1'b0 : 1'b1;
	modport dev (input addr, input chip_select_n, input write_strobe_n,
		input output_strobe_n, input data, output dev_data_o, output dev_data_oe,
		output done_o, output done_oe, output irq_oe, input host_bus_clock,
		input use_host_clock);
	modport host (output addr, output chip_select_n, output write_strobe_n,
		output output_strobe_n, output host_data_o, output host_data_oe,
		input data, input access_done_n, input event_irq_n,
		output host_bus_clock, output use_host_clock);
endinterface : hdp_if

// ### hw/hdp_host.sv
// Host end: turns word requests into strobe cycles on the port.
// Assumes the device on the far side of hdp_if and a single mclk.
`timescale 1ns/100ps
`include "hdp_regs.svh"
module hdp_host #(
	parameter int DW = `HDP_DATA_W,
	parameter int AW = `HDP_ADDR_W
) (
	input  wire logic          mclk,
	input  wire logic          reset,
	hdp_if.host                pins,
	input  wire logic          req_valid,
	input  wire logic          req_write,
	input  wire logic          req_init,
	input  wire logic [AW-1:0] req_addr,
	input  wire logic [DW-1:0] req_wdata,
	input  wire logic          sync_mode,
	output logic               req_ready_q,
	output logic               rsp_valid_q,
	output logic [DW-1:0]      rsp_rdata_q,
	output logic               irq_seen_q
);
	hdp_pkg::hdp_host_st_t st_q;
	logic [1:0] dn_s, ir_s;
	logic [7:0] gap_q;
	logic [7:0] rr_q;
	logic       wr_q, init_q;
	logic [AW-1:0] addr_q;
	logic [DW-1:0] wdata_q;
	logic       ce_q, we_q, oe_q, doe_q, hclk_q;
	logic [DW-1:0] rd_s1_q;
	logic [DW-1:0] rd_s2_q;

	// Done, interrupt and read data pass two flops
	always_ff @(posedge mclk) begin
		dn_s <= {dn_s[0], pins.access_done_n};
		ir_s <= {ir_s[0], pins.event_irq_n};
		rd_s1_q <= pins.data;
		rd_s2_q <= rd_s1_q;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			irq_seen_q <= 1'b0;
		end else begin
			irq_seen_q <= ~ir_s[1];
		end
	end

	// Host bus clock: mclk divided by two
	always_ff @(posedge mclk) begin
		if (reset) begin
			hclk_q <= 1'b0;
		end else begin
			hclk_q <= ~hclk_q;
		end
	end

	// Read-to-read start spacing
	always_ff @(posedge mclk) begin
		if (reset) begin
			rr_q <= 8'h0;
		end else if (st_q == hdp_pkg::HDP_H_SETUP && !wr_q && rr_q == 8'h0) begin
			rr_q <= 8'(`HDP_RR_CYC);
		end else if (rr_q != 8'h0) begin
			rr_q <= rr_q - 8'h1;
		end
	end

	// One 16-bit word per cycle; wide accesses arrive as two requests
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q        <= hdp_pkg::HDP_H_IDLE;
			ce_q        <= 1'b1;
			we_q        <= 1'b1;
			oe_q        <= 1'b1;
			doe_q       <= 1'b0;
			wr_q        <= 1'b0;
			init_q      <= 1'b0;
			addr_q      <= '0;
			wdata_q     <= '0;
			gap_q       <= 8'h0;
			req_ready_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_rdata_q <= '0;
		end else begin
			rsp_valid_q <= 1'b0;
			case (st_q)
				hdp_pkg::HDP_H_IDLE: begin
					req_ready_q <= 1'b1;
					if (req_valid && req_ready_q) begin
						req_ready_q <= 1'b0;
						wr_q    <= req_write;
						init_q  <= req_init;
						addr_q  <= req_addr;
						wdata_q <= req_wdata;
						doe_q   <= req_write;
						st_q    <= hdp_pkg::HDP_H_SETUP;
					end
				end
				hdp_pkg::HDP_H_SETUP: begin
					// Address and data settle before the strobes
					if (wr_q || rr_q == 8'h0) begin
						ce_q <= 1'b0;
						we_q <= ~wr_q;
						oe_q <= wr_q;
						st_q <= hdp_pkg::HDP_H_STROB;
					end
				end
				hdp_pkg::HDP_H_STROB: begin
					// Hold strobes and data until done is seen
					if (!dn_s[1]) begin
						if (!wr_q) begin
							rsp_rdata_q <= rd_s2_q;
						end
						rsp_valid_q <= 1'b1;
						ce_q <= 1'b1;
						we_q <= 1'b1;
						oe_q <= 1'b1;
						st_q <= hdp_pkg::HDP_H_END;
					end
				end
				hdp_pkg::HDP_H_END: begin
					doe_q <= 1'b0;
					// Quiet after enable write, else short gap
					gap_q <= init_q ? 8'(`HDP_INIT_CYC) : 8'(`HDP_GAP_CYC);
					st_q  <= hdp_pkg::HDP_H_GAP;
				end
				hdp_pkg::HDP_H_GAP: begin
					if (gap_q <= 8'h1 && dn_s[1]) begin
						st_q <= hdp_pkg::HDP_H_IDLE;
					end else if (gap_q != 8'h0) begin
						gap_q <= gap_q - 8'h1;
					end
				end
				default: begin
					st_q <= hdp_pkg::HDP_H_IDLE;
				end
			endcase
		end
	end

	assign pins.addr            = addr_q;
	assign pins.chip_select_n   = ce_q;
	assign pins.write_strobe_n  = we_q;
	assign pins.output_strobe_n = oe_q;
	assign pins.host_data_o     = wdata_q;
	assign pins.host_data_oe    = doe_q;
	assign pins.host_bus_clock  = hclk_q;
	assign pins.use_host_clock  = sync_mode;
endmodule : hdp_host

// ### test/hdp_properties.sv
// Concurrent checks on the pins joining host end and device end.
// Assumes one mclk domain with synchronous active-high reset.
`timescale 1ns/100ps
module hdp_properties (
	input wire logic mclk,
	input wire logic reset,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_strobe_n,
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	input wire logic done_o,
	input wire logic done_oe,
	input wire logic access_done_n,
	input wire logic irq_oe,
	input wire logic event_irq_n,
	input wire logic use_host_clock
);
	wire logic wr_act = !chip_select_n && !write_strobe_n;
	wire logic rd_act = !chip_select_n && !output_strobe_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	a_one_driver: assert property (!(dev_data_oe && host_data_oe))
		else $error("Data bus driven by both ends");
	a_data_only_read: assert property ((!rd_act)[*6] |-> !dev_data_oe)
		else $error("Data driven outside a read");
	a_irq_pull_low: assert property (event_irq_n == !irq_oe)
		else $error("Interrupt line not open-drain low");
	a_wr_done_window: assert property (!use_host_clock && $rose(wr_act) |->
		access_done_n[*4] ##[1:8] !access_done_n) else $error("Write done out of window");
	a_rd_done_window: assert property (!use_host_clock && $rose(rd_act) |->
		access_done_n[*5] ##[1:20] !access_done_n) else $error("Read done out of window");
	a_rd_rd_space: assert property ($rose(rd_act) |=> (!$rose(rd_act))[*4])
		else $error("Read starts too close together");
	a_wr_done_drop: assert property (!use_host_clock && $past(wr_act) && !wr_act
		|-> ##[0:3] access_done_n) else $error("Done held after write end");
	a_sync_done_len: assert property (use_host_clock && $fell(access_done_n) |=>
		!access_done_n ##1 access_done_n) else $error("Synchronised done length wrong");
	a_hi_drive_len: assert property ((done_oe && done_o)[*4] |=> !(done_oe && done_o))
		else $error("Done driven high too long");
	a_done_needs_cs: assert property ($fell(access_done_n) |-> !chip_select_n)
		else $error("Done without an access");
endmodule : hdp_properties

// ### test/tb.sv
// Self-checking bench: host end and device end joined by hdp_if.
// Assumes the design files and hdp_regs.svh on the include path.
`timescale 1ns/100ps
module tb;
	`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
		$display("Error at %0t: got %h expected %h", $time, g, e); end end
	logic        mclk            = 1'b0;
	logic        reset           = 1'b1;
	logic [1:0]  ready_high_code = 2'h0;
	logic        event_req       = 1'b0;
	logic        event_clr       = 1'b0;
	logic        req_valid       = 1'b0;
	logic        req_write       = 1'b0;
	logic        req_init        = 1'b0;
	logic [11:0] req_addr        = 12'h000;
	logic [15:0] req_wdata       = 16'h0000;
	logic        sync_mode       = 1'b0;
	logic        event_pending_q;
	logic        wr_seen_q;
	logic [11:0] wr_addr_q;
	logic        req_ready_q;
	logic        rsp_valid_q;
	logic [15:0] rsp_rdata_q;
	logic        irq_seen_q;
	logic [15:0] lfsr_q          = 16'h87f4;
	logic [15:0] mem [4096];
	logic [11:0] al [6];
	int          failures        = 0;
	int          cmp_count       = 0;
	hdp_if bus ();
	hdp_dev hdp_dev_i (.mclk(mclk), .reset(reset), .pins(bus), .ready_high_code(ready_high_code),
		.event_req(event_req), .event_clr(event_clr), .event_pending_q(event_pending_q),
		.wr_seen_q(wr_seen_q), .wr_addr_q(wr_addr_q));
	hdp_host hdp_host_i (.mclk(mclk), .reset(reset), .pins(bus), .req_valid(req_valid),
		.req_write(req_write), .req_init(req_init), .req_addr(req_addr), .req_wdata(req_wdata),
		.sync_mode(sync_mode), .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q),
		.rsp_rdata_q(rsp_rdata_q), .irq_seen_q(irq_seen_q));
	hdp_properties hdp_properties_i (.mclk(mclk), .reset(reset),
		.chip_select_n(bus.chip_select_n), .write_strobe_n(bus.write_strobe_n),
		.output_strobe_n(bus.output_strobe_n), .host_data_oe(bus.host_data_oe),
		.dev_data_oe(bus.dev_data_oe), .done_o(bus.done_o), .done_oe(bus.done_oe),
		.access_done_n(bus.access_done_n), .irq_oe(bus.irq_oe), .event_irq_n(bus.event_irq_n),
		.use_host_clock(bus.use_host_clock));
	always #4 mclk = ~mclk;
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	function automatic logic [15:0] exp_word(input logic [11:0] a);
		return mem[a];
	endfunction : exp_word
	task automatic results();
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	task automatic xfer(input logic w, input logic init, input logic [11:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		while (req_ready_q !== 1'b1 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 300) failures++;
		@(posedge mclk);
		req_valid <= 1'b1;
		req_write <= w;
		req_init  <= init;
		req_addr  <= a;
		req_wdata <= d;
		@(posedge mclk);
		req_valid <= 1'b0;
		n = 0;
		while ((w ? wr_seen_q : rsp_valid_q) !== 1'b1 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 300) failures++;
		if (w) begin
			`CHK(wr_addr_q, a)
			mem[a] = d;
		end else begin
			`CHK(rsp_rdata_q, exp_word(a))
		end
	endtask : xfer
	initial begin
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		for (int m = 0; m < 2; m++) begin
			for (int c = 0; c < 4; c++) begin
				@(posedge mclk);
				sync_mode       <= m[0];
				ready_high_code <= c[1:0];
				lfsr_q = lfsr_next(lfsr_q);
				al = '{12'h000, 12'hfff, 12'h800, lfsr_q[11:0], lfsr_q[11:0] ^ 12'h001,
					lfsr_q[15:4]};
				for (int i = 0; i < 6; i++) begin
					lfsr_q = lfsr_next(lfsr_q);
					xfer(1'b1, 1'b0, al[i], lfsr_q);
				end
				for (int i = 0; i < 6; i++)
					xfer(1'b0, 1'b0, al[i], 16'h0000);
				xfer(1'b1, 1'b1, 12'h010, lfsr_q ^ 16'h5a5a);
				xfer(1'b0, 1'b0, 12'h010, 16'h0000);
			end
		end
		@(posedge mclk);
		event_req <= 1'b1;
		event_clr <= 1'b1;
		@(posedge mclk);
		event_req <= 1'b0;
		event_clr <= 1'b0;
		repeat (8) @(negedge mclk);
		`CHK(event_pending_q, 1'b1)
		`CHK(bus.event_irq_n, 1'b0)
		`CHK(irq_seen_q, 1'b1)
		@(posedge mclk);
		event_clr <= 1'b1;
		@(posedge mclk);
		event_clr <= 1'b0;
		repeat (8) @(negedge mclk);
		`CHK(event_pending_q, 1'b0)
		`CHK(bus.event_irq_n, 1'b1)
		`CHK(irq_seen_q, 1'b0)
		results();
	end
	initial begin
		repeat (60000) @(posedge mclk);
		failures++;
		results();
	end
endmodule : tb
